// *** design/scwp_cfg.svh ***
// Constants for the serial configuration write port
`ifndef SCWP_CFG_SVH
`define SCWP_CFG_SVH
`define SCWP_CNT_W 5
`define SCWP_LAST_BIT 5'h1f
`define SCWP_HDR_MSB 31
`define SCWP_HDR_LSB 20
`define SCWP_HEADER 12'h001
`define SCWP_ADDR_MSB 19
`define SCWP_ADDR_LSB 16
`define SCWP_DATA_MSB 15
`define SCWP_ADDR_CFG 4'h1
`define SCWP_ADDR_OFFSET 4'h2
`define SCWP_ADDR_FSR 4'h3
`define SCWP_CFG_RESET 16'hb2ff
`define SCWP_OFFSET_RESET 16'h007f
`define SCWP_FSR_RESET 16'h807f
`define SCWP_BIT_STAB 12
`define SCWP_BIT_PHASE 11
`define SCWP_BIT_DDR_OFF 10
`define SCWP_BIT_AMP 9
`define SCWP_BIT_OE 8
`endif

// *** design/scwp_pkg.sv ***
// Types shared by the serial configuration write port
package scwp_pkg;
  typedef logic [15:0] scwp_word_t;
  typedef logic [3:0] scwp_addr_t;
  typedef logic [31:0] scwp_frame_t;
endpackage : scwp_pkg

// *** design/scwp_sync.sv ***
// Two-flop synchroniser, one chain per bit
`timescale 1ns/1ps
module scwp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      logic meta_reg;
      logic sync_reg;
      // First stage feeds only the second
      always_ff @(posedge i_core_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end
        else
        begin
          meta_reg <= i_async[gi];
          sync_reg <= meta_reg;
        end
      end
      assign o_sync[gi] = sync_reg;
    end
  endgenerate
endmodule : scwp_sync

// *** design/scwp_top.sv ***
// Serial configuration write port: frame decoder and user registers
`timescale 1ns/1ps
`include "scwp_cfg.svh"
// Summary of operation
// - Serial writes are taken only in extended control mode; otherwise pins ignored.
// - Data is sampled on each serial clock rising edge while select is low.
// - No lower limit on serial clock rate; pauses of any length are fine.
// - A frame is exactly 32 bits, MSB first: header, address, value.
// - The first 12 bits must be eleven zeros then a one.
// - A 4-bit address, MSB first, follows the header, then 16 data bits.
// - The next frame may start at the 33rd clock without toggling select.
// - Frames still decode with select held low permanently.
// - Address 1 is configuration, 2 offset, 3 full scale; others reserved.
// - Registers are write-only; data pin is input only.
// - In normal control mode registers have no effect; pins set DDR, amplitude and edge, the rest are fixed.
// - Configuration register resets to b2ff with control bits 12 to 8.
// - DDR clock phase acts only in double data rate mode.
// - Output edge bit picks the data edge in single data rate mode.
// - Stabilizer bit enables duty cycle stabilisation of the sample clock.
module scwp_top (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ext_ctrl_mode,
  input wire logic i_serial_clk,
  input wire logic i_serial_select_n,
  input wire logic i_serial_data_in,
  input wire logic i_sdr_edge_pin,
  input wire logic i_output_amplitude_pin,
  input wire logic i_ddr_float_pin,
  output logic o_duty_cycle_stabilizer_en,
  output logic o_ddr_clock_phase,
  output logic o_ddr_disable,
  output logic o_output_amplitude_select,
  output logic o_sdr_edge,
  output scwp_pkg::scwp_word_t o_input_offset_adjust,
  output scwp_pkg::scwp_word_t o_full_scale_range_adjust,
  output logic o_write_strobe,
  output logic o_frame_reject
);
  logic s_mode;
  logic s_sclk;
  logic s_sel_n;
  logic s_data;
  logic s_edge_pin;
  logic s_amp_pin;
  logic s_ddr_float;
  logic sclk_d_reg;
  logic sclk_rise;
  logic active;
  logic [`SCWP_CNT_W-1:0] cnt_reg, cnt_next;
  logic [30:0] shift_reg, shift_next;
  scwp_pkg::scwp_frame_t last_word;
  scwp_pkg::scwp_addr_t last_addr;
  logic hdr_ok;
  scwp_pkg::scwp_word_t cfg_reg, cfg_next;
  scwp_pkg::scwp_word_t offset_reg, offset_next;
  scwp_pkg::scwp_word_t fsr_reg, fsr_next;
  logic wr_next, rej_next;
  logic stab_next, phase_next, ddr_off_next, amp_next, oe_next;
  scwp_pkg::scwp_word_t off_out_next, fsr_out_next;

  // All pins cross into the core clock through two flops
  scwp_sync #(.WIDTH(7)) i_scwp_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async({i_ext_ctrl_mode, i_serial_clk, i_serial_select_n, i_serial_data_in,
              i_sdr_edge_pin, i_output_amplitude_pin, i_ddr_float_pin}),
    .o_sync({s_mode, s_sclk, s_sel_n, s_data, s_edge_pin, s_amp_pin, s_ddr_float})
  );

  // Edge finder and frame field views
  // rising serial clock edge
  assign sclk_rise = s_sclk & ~sclk_d_reg;
  // only extended mode with select low
  assign active = s_mode & ~s_sel_n;
  assign last_word = {shift_reg, s_data};
  assign last_addr = last_word[`SCWP_ADDR_MSB:`SCWP_ADDR_LSB];
  assign hdr_ok = (last_word[`SCWP_HDR_MSB:`SCWP_HDR_LSB] == `SCWP_HEADER);

  // Shifter, bit counter and register writes
  always_comb
  begin
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    cfg_next = cfg_reg;
    offset_next = offset_reg;
    fsr_next = fsr_reg;
    wr_next = 1'b0;
    rej_next = 1'b0;
    if (!active)
    begin
      cnt_next = '0;
    end
    else if (sclk_rise)
    begin
      shift_next = last_word[30:0];
      if (cnt_reg == `SCWP_LAST_BIT)
      begin
        cnt_next = '0;
        if (!hdr_ok)
        begin
          rej_next = 1'b1;
        end
        else
        begin
          // low 16 bits are the value
          case (last_addr)
            `SCWP_ADDR_CFG:
            begin
              cfg_next = last_word[`SCWP_DATA_MSB:0];
              wr_next = 1'b1;
            end
            `SCWP_ADDR_OFFSET:
            begin
              offset_next = last_word[`SCWP_DATA_MSB:0];
              wr_next = 1'b1;
            end
            `SCWP_ADDR_FSR:
            begin
              fsr_next = last_word[`SCWP_DATA_MSB:0];
              wr_next = 1'b1;
            end
            default:
            begin
              rej_next = 1'b1;
            end
          endcase
        end
      end
      else
      begin
        cnt_next = `SCWP_CNT_W'(cnt_reg + 1'b1);
      end
    end
  end

  // Effective controls towards the converter
  always_comb
  begin
    if (s_mode)
    begin
      stab_next = cfg_reg[`SCWP_BIT_STAB];
      ddr_off_next = cfg_reg[`SCWP_BIT_DDR_OFF];
      amp_next = cfg_reg[`SCWP_BIT_AMP];
      oe_next = cfg_reg[`SCWP_BIT_OE];
      phase_next = cfg_reg[`SCWP_BIT_PHASE];
      off_out_next = offset_reg;
      fsr_out_next = fsr_reg;
    end
    else
    begin
      stab_next = 1'b1;
      ddr_off_next = ~s_ddr_float;
      amp_next = s_amp_pin;
      oe_next = s_edge_pin;
      phase_next = 1'b0;
      off_out_next = `SCWP_OFFSET_RESET;
      fsr_out_next = `SCWP_FSR_RESET;
    end
    if (ddr_off_next)
    begin
      phase_next = 1'b0;
    end
  end

  // State and output registers
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sclk_d_reg <= 1'b0;
      cnt_reg <= '0;
      shift_reg <= '0;
      cfg_reg <= `SCWP_CFG_RESET;
      offset_reg <= `SCWP_OFFSET_RESET;
      fsr_reg <= `SCWP_FSR_RESET;
      o_write_strobe <= 1'b0;
      o_frame_reject <= 1'b0;
      o_duty_cycle_stabilizer_en <= 1'b1;
      o_ddr_clock_phase <= 1'b0;
      o_ddr_disable <= 1'b0;
      o_output_amplitude_select <= 1'b1;
      o_sdr_edge <= 1'b0;
      o_input_offset_adjust <= `SCWP_OFFSET_RESET;
      o_full_scale_range_adjust <= `SCWP_FSR_RESET;
    end
    else
    begin
      sclk_d_reg <= s_sclk;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      cfg_reg <= cfg_next;
      offset_reg <= offset_next;
      fsr_reg <= fsr_next;
      o_write_strobe <= wr_next;
      o_frame_reject <= rej_next;
      o_duty_cycle_stabilizer_en <= stab_next;
      o_ddr_clock_phase <= phase_next;
      o_ddr_disable <= ddr_off_next;
      o_output_amplitude_select <= amp_next;
      o_sdr_edge <= oe_next;
      o_input_offset_adjust <= off_out_next;
      o_full_scale_range_adjust <= fsr_out_next;
    end
  end

  // Checks on the frame decoder and the output controls
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  sequence last_bit;
    active && sclk_rise && (cnt_reg == `SCWP_LAST_BIT);
  endsequence

  sequence good_cfg_frame;
    last_bit and (hdr_ok && last_addr == `SCWP_ADDR_CFG);
  endsequence

  a_normal_ignored:
    assert property (!s_mode |=> (cnt_reg == 5'h00) && !o_write_strobe)
    else $error("serial activity taken in normal mode");
  a_select_abort:
    assert property (s_sel_n |=> cnt_reg == 5'h00)
    else $error("partial frame kept after select rose");
  a_count_on_edge:
    assert property (active && sclk_rise && cnt_reg != `SCWP_LAST_BIT
                     |=> cnt_reg == $past(cnt_reg) + 5'h01)
    else $error("bit count missed a serial edge");
  a_hold_between_edges:
    assert property (active && !sclk_rise |=> $stable(cnt_reg) && $stable(shift_reg))
    else $error("decoder moved without a serial edge");
  a_wrap_back_to_back:
    assert property (last_bit |=> cnt_reg == 5'h00)
    else $error("counter did not wrap after bit 32");
  a_bad_header_dropped:
    assert property (last_bit and !hdr_ok
                     |=> o_frame_reject && !o_write_strobe && $stable(cfg_reg)
                         && $stable(offset_reg) && $stable(fsr_reg))
    else $error("bad header frame was not dropped");
  a_cfg_written:
    assert property (good_cfg_frame |=> o_write_strobe
                     && cfg_reg == $past(last_word[`SCWP_DATA_MSB:0]))
    else $error("configuration write lost");
  a_normal_pins_rule:
    assert property (!s_mode |=> o_sdr_edge == $past(s_edge_pin)
                     && o_output_amplitude_select == $past(s_amp_pin))
    else $error("register steered outputs in normal mode");
  a_phase_ddr_only:
    assert property (o_ddr_disable |-> !o_ddr_clock_phase)
    else $error("clock phase active outside DDR");
endmodule : scwp_top

// *** tb/scwp_host.sv ***
// Host model that shifts frames into the serial write port
`timescale 1ns/1ps
module scwp_host (
  input wire logic i_core_clk,
  output logic o_serial_clk,
  output logic o_select_n,
  output logic o_data
);
  // Link idle: clock still, select high
  initial
  begin
    o_serial_clk = 1'b0;
    o_select_n = 1'b1;
    o_data = 1'b0;
  end
  task automatic send(input logic [63:0] w, input int nbits, input int half);
    @(posedge i_core_clk);
    o_select_n <= 1'b0;
    for (int k = nbits - 1; k >= 0; k--)
    begin
      o_data <= w[k]; // Changes while serial clock is low
      repeat (half) @(posedge i_core_clk);
      o_serial_clk <= 1'b1;
      repeat (half) @(posedge i_core_clk);
      o_serial_clk <= 1'b0;
    end
    repeat (8) @(posedge i_core_clk);
    o_data <= ~o_data; // Released line does not keep its value
    o_select_n <= 1'b1;
  endtask : send
endmodule : scwp_host

// *** tb/scwp_top_tb_top.sv ***
// Testbench for the serial configuration write port
`timescale 1ns/1ps
module scwp_top_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mode = 1'b1;
  logic edge_pin = 1'b0;
  logic amp_pin = 1'b0;
  logic float_pin = 1'b0;
  logic sclk, sel_n, serial_data_in, stab, phase, ddr_off, amp, oe, ws, rej;
  scwp_pkg::scwp_word_t offs, fsr;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_ws = 0;
  int n_rej = 0;

  // Core clock, 4 ns
  always #2 clk = ~clk;

  scwp_host i_scwp_host (.i_core_clk(clk), .o_serial_clk(sclk), .o_select_n(sel_n),
    .o_data(serial_data_in));

  scwp_top i_scwp_top (.i_core_clk(clk), .i_rst(rst), .i_ext_ctrl_mode(mode),
    .i_serial_clk(sclk), .i_serial_select_n(sel_n), .i_serial_data_in(serial_data_in),
    .i_sdr_edge_pin(edge_pin), .i_output_amplitude_pin(amp_pin), .i_ddr_float_pin(float_pin),
    .o_duty_cycle_stabilizer_en(stab), .o_ddr_clock_phase(phase), .o_ddr_disable(ddr_off),
    .o_output_amplitude_select(amp), .o_sdr_edge(oe), .o_input_offset_adjust(offs),
    .o_full_scale_range_adjust(fsr), .o_write_strobe(ws), .o_frame_reject(rej));

  // Strobe counters
  always @(posedge clk)
  begin
    if (ws === 1'b1) n_ws++;
    if (rej === 1'b1) n_rej++;
  end

  function automatic logic [31:0] fr(input logic [3:0] a, input logic [15:0] d);
    return {12'h001, a, d};
  endfunction : fr

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Send one frame and let the strobe land
  task automatic put(input logic [31:0] f);
    i_scwp_host.send({32'h0000_0000, f}, 32, 8);
    repeat (4) @(posedge clk);
  endtask : put

  task automatic stop_test;
    if (n_mismatch == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // Watchdog
  initial
  begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check("cfg_reset", {11'h000, stab, phase, ddr_off, amp, oe}, 16'h0012);
    check("offset_reset", offs, 16'h007f);
    check("fsr_reset", fsr, 16'h807f);
    // first use writes the configuration register
    put(fr(4'h1, 16'ha9ff));
    check("cfg_write", {11'h000, stab, phase, ddr_off, amp, oe}, 16'h0009);
    // two frames, select held low across the 33rd clock
    i_scwp_host.send({fr(4'h2, 16'h1234), fr(4'h3, 16'h5678)}, 64, 8);
    repeat (4) @(posedge clk);
    check("offset", offs, 16'h1234);
    check("fsr", fsr, 16'h5678);
    check("strobes", n_ws[15:0], 16'h0003);
    // Phase forced low in single data rate
    put(fr(4'h1, 16'hbcff));
    check("cfg_sdr", {11'h000, stab, phase, ddr_off, amp, oe}, 16'h0014);
    // Reserved addresses are dropped
    for (int a = 0; a < 16; a++)
      if (a == 0 || a > 3) put(fr(a[3:0], 16'h0000));
    put({12'h003, 4'h2, 16'hffff}); // Header with a wrong bit
    check("rejects", n_rej[15:0], 16'h000e);
    check("offset_kept", offs, 16'h1234);
    // Partial frame then select high
    i_scwp_host.send({32'h0000_0000, fr(4'h2, 16'hdead) >> 12}, 20, 8);
    i_scwp_host.send({32'h0000_0000, fr(4'h2, 16'h00ff)}, 32, 200);
    repeat (4) @(posedge clk);
    check("offset_resync", offs, 16'h00ff);
    check("strobes2", n_ws[15:0], 16'h0005);
    // Normal mode: serial ignored, pins set edge, amplitude and DDR, the rest fixed
    mode <= 1'b0;
    edge_pin <= 1'b1;
    float_pin <= 1'b1;
    put(fr(4'h2, 16'hbeef));
    check("cfg_normal", {11'h000, stab, phase, ddr_off, amp, oe}, 16'h0011);
    check("offset_normal", offs, 16'h007f);
    check("fsr_normal", fsr, 16'h807f);
    check("strobes3", n_ws[15:0], 16'h0005);
    mode <= 1'b1;
    repeat (8) @(posedge clk);
    check("offset_back", offs, 16'h00ff);
    check("cfg_back", {11'h000, stab, phase, ddr_off, amp, oe}, 16'h0014);
    stop_test();
  end
endmodule : scwp_top_tb_top
